// ### ssp_map.svh
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

`define SSP_DATA_W   16
`define SSP_DEPTH    8
`define SSP_MSG_BITS 8
`define SSP_MSG_GAP  1
`define SSP_RT_BITS  32
`define SSP_TX_LVL   4
`define SSP_RX_LVL   4
`define SSP_FSS_IDLE 1'b1

`endif

// ### ssp_pkg.sv
`default_nettype none
package ssp_pkg;

	typedef enum logic [1:0] {
		SSP_FMT_SPI    = 2'h0,
		SSP_FMT_FRAMED = 2'h1,
		SSP_FMT_MSG    = 2'h2
	} ssp_fmt_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_LEAD  = 2'h1,
		ST_SHIFT = 2'h3,
		ST_TAIL  = 2'h2
	} ssp_state_t;

	typedef struct packed {
		logic       enable;
		logic       master;
		ssp_fmt_t   fmt;
		logic [3:0] size_m1;
		logic [7:0] prescale_divisor;
		logic [7:0] serial_clock_rate;
	} ssp_cfg_t;

	typedef struct packed {
		logic tx_svc;
		logic rx_svc;
		logic rx_tmo;
		logic rx_ovr;
	} ssp_irq_t;

endpackage
`default_nettype wire

// ### ssp_fifo.sv
`default_nettype none
module ssp_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic         push,
	input  wire logic [W-1:0] push_data,
	input  wire logic         pop,
	output logic      [W-1:0] peek_data,
	output logic      [AW:0]  count,
	output logic              full,
	output logic              empty
);
	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	logic          push_ok;
	logic          pop_ok;

	assign full    = count_r == (AW+1)'(DEPTH);
	assign empty   = count_r == '0;
	assign push_ok = push && !full;
	assign pop_ok  = pop && !empty;
	assign count   = count_r;
	// When empty the read slot is the one written DEPTH writes ago
	assign peek_data = mem_r[rd_ptr_r];

	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		always_ff @(posedge clk_sys) begin
			if (!rst_n)
				mem_r[i] <= '0;
			else if (push_ok && wr_ptr_r == AW'(i))
				mem_r[i] <= push_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push_ok)
				wr_ptr_r <= wr_ptr_r + AW'(1);
			if (pop_ok)
				rd_ptr_r <= rd_ptr_r + AW'(1);
			count_r <= count_r + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_no_overfill;
		push && full && !pop |=> count_r == $past(count_r);
	endproperty
	a_no_overfill: assert property (p_no_overfill)
		else $error("fifo accepted a push while full");

endmodule
`default_nettype wire

// ### ssp_top.sv
`include "ssp_map.svh"
`default_nettype none
module ssp_top
	import ssp_pkg::*;
#(
	parameter int DEPTH   = `SSP_DEPTH,
	parameter int RT_BITS = `SSP_RT_BITS
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst_n,
	input  wire ssp_cfg_t                cfg,
	input  wire ssp_irq_t                interrupt_mask_register,
	input  wire logic                    clr_tmo,
	input  wire logic                    clr_ovr,
	input  wire logic                    tx_push,
	input  wire logic [`SSP_DATA_W-1:0]  tx_data,
	output var  logic                    tx_ready_r,
	input  wire logic                    rx_pop,
	output var  logic [`SSP_DATA_W-1:0]  rx_data_r,
	output var  logic                    rx_avail_r,
	output var  ssp_irq_t                raw_interrupt_state_r,
	output var  ssp_irq_t                masked_interrupt_state_r,
	output var  logic                    irq_r,
	output var  logic                    dma_tx_req_r,
	input  wire logic                    serial_bit_clock_in,
	output var  logic                    serial_bit_clock_r,
	output var  logic                    serial_bit_clock_oe_n_r,
	input  wire logic                    frame_select_line_in,
	output var  logic                    frame_select_line_r,
	output var  logic                    frame_select_line_oe_n_r,
	input  wire logic                    serial_in_line,
	output var  logic                    serial_out_line_r,
	output var  logic                    serial_out_line_oe_n_r
);
	localparam int W   = `SSP_DATA_W;
	localparam int AW  = $clog2(DEPTH);
	localparam int RTH = 2 * RT_BITS;
	localparam int RTW = $clog2(RTH + 1);
	localparam logic [4:0]    MSG_SKIP = 5'(`SSP_MSG_BITS + `SSP_MSG_GAP);
	localparam logic [AW:0]   TX_LVL   = (AW+1)'(`SSP_TX_LVL);
	localparam logic [AW:0]   RX_LVL   = (AW+1)'(`SSP_RX_LVL);
	localparam logic [RTW-1:0] RT_END  = RTW'(RTH - 1);

	ssp_state_t     state_r;
	logic [6:0]     psc_cnt_r;
	logic [6:0]     psc_half;
	logic [7:0]     scr_cnt_r;
	logic           pre_tick;
	logic           half_tick;
	logic [1:0]     sclk_s_r;
	logic [1:0]     fss_s_r;
	logic [1:0]     sdi_s_r;
	logic           sclk_d_r;
	logic           fss_d_r;
	logic           master;
	logic           fmt_frm;
	logic           fmt_msg;
	logic           m_tick;
	logic           ev_rise;
	logic           ev_fall;
	logic           samp;
	logic           drive;
	logic           take;
	logic           done;
	logic           start_m;
	logic           start_s;
	logic           load;
	logic           tx_pop;
	logic [4:0]     nbits;
	logic [4:0]     tot;
	logic [4:0]     bit_cnt_r;
	logic [W-1:0]   mask;
	logic [W-1:0]   tx_word;
	logic [W-1:0]   tx_sh_r;
	logic [W-1:0]   rx_sh_r;
	logic [W-1:0]   rx_sh_nxt;
	logic [W-1:0]   hold_r;
	logic           hold_vld_r;
	logic [W-1:0]   tx_peek;
	logic [W-1:0]   rx_peek;
	logic [AW:0]    tx_cnt;
	logic [AW:0]    rx_cnt;
	logic           tx_full;
	logic           tx_empty;
	logic           rx_full;
	logic           rx_empty;
	logic [RTW-1:0] rt_cnt_r;
	logic           rt_hit;
	ssp_irq_t       raw_nxt;
	ssp_irq_t       mis_nxt;

	// Odd divisors lose bit 0, so the full period is always even
	always_comb begin
		psc_half = cfg.prescale_divisor[7:1];
		if (psc_half == 7'h00)
			psc_half = 7'h01;
	end

	assign pre_tick  = psc_cnt_r >= psc_half - 7'h01;
	assign half_tick = pre_tick && scr_cnt_r >= cfg.serial_clock_rate;

	always_ff @(posedge clk_sys) begin
		if (!rst_n || pre_tick)
			psc_cnt_r <= 7'h00;
		else
			psc_cnt_r <= psc_cnt_r + 7'h01;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || half_tick)
			scr_cnt_r <= 8'h00;
		else if (pre_tick)
			scr_cnt_r <= scr_cnt_r + 8'h01;
	end

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sclk_s_r <= 2'h0;
			fss_s_r  <= 2'h3;
			sdi_s_r  <= 2'h0;
			sclk_d_r <= 1'b0;
			fss_d_r  <= 1'b1;
		end else begin
			sclk_s_r <= {sclk_s_r[0], serial_bit_clock_in};
			fss_s_r  <= {fss_s_r[0], frame_select_line_in};
			sdi_s_r  <= {sdi_s_r[0], serial_in_line};
			sclk_d_r <= sclk_s_r[1];
			fss_d_r  <= fss_s_r[1];
		end
	end

	assign master  = cfg.master;
	assign fmt_frm = cfg.fmt == SSP_FMT_FRAMED;
	assign fmt_msg = master && cfg.fmt == SSP_FMT_MSG;
	assign m_tick  = master && half_tick;
	assign ev_rise = master ? m_tick && !serial_bit_clock_r
		: sclk_s_r[1] && !sclk_d_r;
	assign ev_fall = master ? m_tick && serial_bit_clock_r
		: !sclk_s_r[1] && sclk_d_r;
	assign samp  = state_r == ST_SHIFT && (fmt_frm ? ev_fall : ev_rise);
	assign drive = state_r == ST_SHIFT && (fmt_frm ? ev_rise : ev_fall);
	assign take  = !fmt_msg || bit_cnt_r >= MSG_SKIP;
	assign nbits = {1'b0, cfg.size_m1} + 5'h01;
	assign tot   = fmt_msg ? nbits + MSG_SKIP : nbits;
	assign done  = samp && bit_cnt_r == tot - 5'h01;
	assign mask  = {W{1'b1}} >> (4'hf - cfg.size_m1);
	// Word is left aligned so the top bit leaves first
	assign tx_word = fmt_msg ? {tx_peek[7:0], 8'h00}
		: tx_peek << (4'hf - cfg.size_m1);
	assign rx_sh_nxt = samp && take ? {rx_sh_r[W-2:0], sdi_s_r[1]}
		: rx_sh_r;

	assign start_m = state_r == ST_IDLE && cfg.enable && m_tick
		&& !tx_empty;
	// A slave starts even with an empty queue and replays the old slot
	assign start_s = state_r == ST_IDLE && cfg.enable && !master
		&& (fmt_frm ? ev_rise && fss_s_r[1]
		: !fss_s_r[1] && fss_d_r);
	assign load   = start_m || start_s;
	assign tx_pop = load && !tx_empty;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r             <= ST_IDLE;
			bit_cnt_r           <= 5'h00;
			tx_sh_r             <= '0;
			rx_sh_r             <= '0;
			serial_bit_clock_r  <= 1'b0;
			frame_select_line_r <= `SSP_FSS_IDLE;
			serial_out_line_r   <= 1'b0;
		end else begin
			rx_sh_r <= rx_sh_nxt;
			unique case (state_r)
			ST_IDLE: begin
				bit_cnt_r <= 5'h00;
				if (load && fmt_frm) begin
					tx_sh_r <= tx_word;
					state_r <= ST_LEAD;
					if (master) begin
						serial_bit_clock_r  <= 1'b1;
						frame_select_line_r <= 1'b1;
					end
				end else if (load) begin
					tx_sh_r           <= tx_word << 1;
					serial_out_line_r <= tx_word[W-1];
					state_r <= master ? ST_LEAD : ST_SHIFT;
					if (master)
						frame_select_line_r <= 1'b0;
				end else if (master) begin
					// Idle select level follows the chosen format
					frame_select_line_r <= !fmt_frm;
				end
			end
			ST_LEAD: begin
				if (fmt_frm ? ev_fall : m_tick) begin
					serial_bit_clock_r <= 1'b0;
					state_r            <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (m_tick)
					serial_bit_clock_r <= !serial_bit_clock_r;
				if (drive) begin
					serial_out_line_r <= tx_sh_r[W-1];
					tx_sh_r           <= tx_sh_r << 1;
					if (master && fmt_frm)
						frame_select_line_r <= 1'b0;
				end
				if (samp)
					bit_cnt_r <= bit_cnt_r + 5'h01;
				if (done)
					state_r <= master ? ST_TAIL : ST_IDLE;
				// Slave select released mid-frame abandons the frame
				if (!master && !fmt_frm && fss_s_r[1])
					state_r <= ST_IDLE;
			end
			ST_TAIL: begin
				if (m_tick && serial_bit_clock_r) begin
					serial_bit_clock_r <= 1'b0;
				end else if (m_tick) begin
					frame_select_line_r <= !fmt_frm;
					state_r             <= ST_IDLE;
				end
			end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			serial_bit_clock_oe_n_r  <= 1'b1;
			frame_select_line_oe_n_r <= 1'b1;
			serial_out_line_oe_n_r   <= 1'b1;
		end else begin
			serial_bit_clock_oe_n_r  <= !(cfg.enable && master);
			frame_select_line_oe_n_r <= !(cfg.enable && master);
			serial_out_line_oe_n_r   <= state_r == ST_IDLE && !load;
		end
	end

	// Received word waits one cycle here before entering the queue
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hold_r     <= '0;
			hold_vld_r <= 1'b0;
		end else begin
			hold_vld_r <= done;
			if (done)
				hold_r <= rx_sh_nxt & mask;
		end
	end

	ssp_fifo #(.W(W), .DEPTH(DEPTH)) u_tx_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.push      (tx_push),
		.push_data (tx_data),
		.pop       (tx_pop),
		.peek_data (tx_peek),
		.count     (tx_cnt),
		.full      (tx_full),
		.empty     (tx_empty)
	);

	ssp_fifo #(.W(W), .DEPTH(DEPTH)) u_rx_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.push      (hold_vld_r),
		.push_data (hold_r),
		.pop       (rx_pop),
		.peek_data (rx_peek),
		.count     (rx_cnt),
		.full      (rx_full),
		.empty     (rx_empty)
	);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tx_ready_r   <= 1'b0;
			rx_avail_r   <= 1'b0;
			rx_data_r    <= '0;
			dma_tx_req_r <= 1'b0;
		end else begin
			tx_ready_r   <= !tx_full;
			rx_avail_r   <= !rx_empty;
			dma_tx_req_r <= tx_empty;
			if (rx_pop && !rx_empty)
				rx_data_r <= rx_peek;
		end
	end

	// Timeout runs on the divider while the link rests with data queued
	always_ff @(posedge clk_sys) begin
		if (!rst_n || state_r != ST_IDLE || rx_empty || rx_pop)
			rt_cnt_r <= '0;
		else if (half_tick && rt_cnt_r != RT_END)
			rt_cnt_r <= rt_cnt_r + RTW'(1);
	end

	assign rt_hit = half_tick && rt_cnt_r == RT_END - RTW'(1);

	always_comb begin
		raw_nxt.tx_svc = tx_cnt <= TX_LVL;
		raw_nxt.rx_svc = rx_cnt >= RX_LVL;
		raw_nxt.rx_tmo = rt_hit
			|| (raw_interrupt_state_r.rx_tmo && !clr_tmo);
		raw_nxt.rx_ovr = (hold_vld_r && rx_full)
			|| (raw_interrupt_state_r.rx_ovr && !clr_ovr);
		mis_nxt = raw_nxt & interrupt_mask_register;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			raw_interrupt_state_r    <= '0;
			masked_interrupt_state_r <= '0;
			irq_r                    <= 1'b0;
		end else begin
			raw_interrupt_state_r    <= raw_nxt;
			masked_interrupt_state_r <= mis_nxt;
			irq_r                    <= |mis_nxt;
		end
	end

	logic [15:0] gap_r;
	ssp_cfg_t    cfg_q_r;
	logic        div_ok_r;

	always_ff @(posedge clk_sys) begin
		if (!rst_n || half_tick)
			gap_r <= 16'h0000;
		else
			gap_r <= gap_r + 16'h0001;
	end

	// Divider checks skip the first half tick after a config change
	always_ff @(posedge clk_sys) begin
		cfg_q_r <= cfg;
		if (!rst_n || cfg != cfg_q_r)
			div_ok_r <= 1'b0;
		else if (half_tick)
			div_ok_r <= 1'b1;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_psc;
		pre_tick && div_ok_r && cfg == cfg_q_r
		|-> psc_cnt_r == psc_half - 7'h01;
	endproperty
	a_psc: assert property (p_psc)
		else $error("prescale tick at wrong count");

	property p_rate;
		half_tick && $past(half_tick, 1) == 1'b0 && gap_r != 16'h0000
		&& div_ok_r && cfg == cfg_q_r
		|-> gap_r == 16'(32'(psc_half)
			* (32'(cfg.serial_clock_rate) + 1) - 1);
	endproperty
	a_rate: assert property (p_rate)
		else $error("half bit period length wrong");

	property p_echo;
		start_s && !fmt_frm |=> serial_out_line_r == $past(tx_word[W-1]);
	endproperty
	a_echo: assert property (p_echo)
		else $error("slave did not send the queued slot");

	property p_dma;
		tx_empty |=> dma_tx_req_r;
	endproperty
	a_dma: assert property (p_dma)
		else $error("empty transmit queue without request");

	property p_hold;
		done |=> hold_vld_r && hold_r == $past(rx_sh_nxt & mask);
	endproperty
	a_hold: assert property (p_hold)
		else $error("holding stage missed a frame");

	property p_irq;
		irq_r == (masked_interrupt_state_r != 4'h0);
	endproperty
	a_irq: assert property (p_irq)
		else $error("request line disagrees with masked state");

	property p_mask;
		##1 (masked_interrupt_state_r & ~$past(interrupt_mask_register))
			== 4'h0;
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked source reached the request");

	property p_idle_clk;
		state_r == ST_IDLE |-> !serial_bit_clock_r;
	endproperty
	a_idle_clk: assert property (p_idle_clk)
		else $error("bit clock not at rest while idle");

	property p_tmo;
		rt_hit |=> raw_interrupt_state_r.rx_tmo;
	endproperty
	a_tmo: assert property (p_tmo)
		else $error("timeout not flagged");

	property p_sel_low;
		master && !fmt_frm && state_r == ST_SHIFT |-> !frame_select_line_r;
	endproperty
	a_sel_low: assert property (p_sel_low)
		else $error("frame select high inside a frame");

	property p_pulse;
		master && $rose(frame_select_line_r) && fmt_frm
		|-> $rose(serial_bit_clock_r);
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("frame pulse not on a rising clock");

	property p_msg_quiet;
		samp && fmt_msg && bit_cnt_r < MSG_SKIP |=> rx_sh_r == $past(rx_sh_r);
	endproperty
	a_msg_quiet: assert property (p_msg_quiet)
		else $error("data captured during control message");

	property p_ovr;
		hold_vld_r && rx_full |=> raw_interrupt_state_r.rx_ovr;
	endproperty
	a_ovr: assert property (p_ovr)
		else $error("overrun not flagged");

	c_m_done: cover property (master && done);
	c_s_done: cover property (!master && done);
	c_ovr:    cover property (hold_vld_r && rx_full);
	c_tmo:    cover property (rt_hit);

endmodule
`default_nettype wire

// ### ssp_far_slave.sv
`default_nettype none
// Off-chip slave facing the block in master mode
module ssp_far_slave
	import ssp_pkg::*;
(
	input  wire logic        sclk,
	input  wire logic        fss,
	input  wire logic        mosi,
	input  wire ssp_fmt_t    fmt,
	input  wire logic [15:0] reply,
	input  wire logic [4:0]  nbits,
	output var  logic        miso,
	output var  logic [15:0] got,
	output var  int          rises
);
	timeunit 1ns;
	timeprecision 1ns;
	int idx;
	initial begin
		miso = 1'b0;
		got = 16'h0;
		rises = 0;
		idx = 0;
	end
	// Delays let select and clock from the same edge both settle
	always @(negedge fss) begin
		#1;
		if (fmt != SSP_FMT_FRAMED) begin
			rises = 0;
			got = 16'h0;
			idx = 1;
			miso = (fmt == SSP_FMT_SPI) ? reply[nbits-1] : ~miso;
		end
	end
	// Deselected line never keeps its last value
	always @(posedge fss) begin
		#1;
		if (fmt != SSP_FMT_FRAMED)
			miso = ~miso;
	end
	always @(posedge sclk) begin
		#1;
		if (fmt == SSP_FMT_FRAMED && fss) begin
			rises = 0;
			got = 16'h0;
			idx = 0;
		end else if (fmt == SSP_FMT_FRAMED) begin
			miso = (idx < nbits) ? reply[nbits-1-idx] : ~miso;
			idx++;
		end else if (!fss) begin
			rises++;
			if (fmt != SSP_FMT_MSG || rises <= 8)
				got = {got[14:0], mosi};
		end
	end
	always @(negedge sclk) begin
		#1;
		if (fmt == SSP_FMT_FRAMED && idx > 0 && idx <= nbits) begin
			got = {got[14:0], mosi};
			rises++;
			if (idx == nbits)
				miso = ~miso;
		end else if (fmt == SSP_FMT_SPI && !fss) begin
			miso = (idx < nbits) ? reply[nbits-1-idx] : ~miso;
			idx++;
		end else if (fmt == SSP_FMT_MSG && !fss) begin
			miso = (rises > 8 && rises < nbits + 9)
				? reply[nbits+8-rises] : ~miso;
		end
	end
endmodule
`default_nettype wire

// ### ssp_top_test.sv
`default_nettype none
module ssp_top_test;
	import ssp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, rst_n, clr_tmo, clr_ovr, tx_push, rx_pop;
	logic        sclk_in, fss_in, sin_b, sin, miso, txr_o, dma_o, irq_o;
	logic        sclk_o, fss_o, sout_o, oe_o, sclk_q, fss_q;
	logic        rxa_o, coe_o, foe_o;
	logic [15:0] tx_data, rx_o, reply, got;
	logic [4:0]  nbits;
	ssp_cfg_t    cfg;
	ssp_irq_t    mask, raw_o, msk_o;
	int          failures, n_checks, rises, cyc, last_rise, period;
	int          fss_cnt, fss_w;
	logic [15:0] hist[$];

	assign sin = cfg.master ? miso : sin_b;
	ssp_top #(.RT_BITS(2)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.cfg(cfg), .interrupt_mask_register(mask), .clr_tmo(clr_tmo),
		.clr_ovr(clr_ovr), .tx_push(tx_push), .tx_data(tx_data),
		.tx_ready_r(txr_o), .rx_pop(rx_pop), .rx_data_r(rx_o),
		.rx_avail_r(rxa_o), .raw_interrupt_state_r(raw_o),
		.masked_interrupt_state_r(msk_o), .irq_r(irq_o),
		.dma_tx_req_r(dma_o), .serial_bit_clock_in(sclk_in),
		.serial_bit_clock_r(sclk_o), .serial_bit_clock_oe_n_r(coe_o),
		.frame_select_line_in(fss_in), .frame_select_line_r(fss_o),
		.frame_select_line_oe_n_r(foe_o), .serial_in_line(sin),
		.serial_out_line_r(sout_o), .serial_out_line_oe_n_r(oe_o));
	ssp_far_slave far_u (.sclk(sclk_o), .fss(fss_o), .mosi(sout_o),
		.fmt(cfg.fmt), .reply(reply), .nbits(nbits), .miso(miso),
		.got(got), .rises(rises));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Bit clock period and select-high width, in system cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (sclk_o && !sclk_q) begin
			period = cyc - last_rise;
			last_rise = cyc;
		end
		if (fss_o)
			fss_cnt++;
		else begin
			if (fss_q)
				fss_w = fss_cnt;
			fss_cnt = 0;
		end
		sclk_q = sclk_o;
		fss_q = fss_o;
	end

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic setcfg(input logic m, input ssp_fmt_t f,
		input logic [3:0] sz, input logic [7:0] ps, input logic [7:0] sr);
		@(negedge clk_sys);
		cfg = '{1'b1, m, f, sz, ps, sr};
		nbits = 5'(sz) + 5'h1;
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic mframe(input logic [15:0] d, input logic [15:0] r);
		int n;
		reply = r;
		@(negedge clk_sys);
		tx_push = 1'b1;
		tx_data = d;
		hist.push_back(d);
		@(negedge clk_sys);
		tx_push = 1'b0;
		n = 0;
		while (oe_o !== 1'b0 && n < 2000) begin
			@(negedge clk_sys);
			n++;
		end
		while (oe_o !== 1'b1 && n < 4000) begin
			@(negedge clk_sys);
			n++;
		end
		chk("frame_end", 16'h1, {15'h0, oe_o});
		chk("sclk_idle", 16'h0, {15'h0, sclk_o});
		chk("sclk_oe", 16'h0, {15'h0, coe_o});
		chk("fss_oe", 16'h0, {15'h0, foe_o});
		repeat (6) @(negedge clk_sys);
	endtask
	task automatic pop_chk(input string what, input logic [15:0] exp);
		@(negedge clk_sys);
		rx_pop = 1'b1;
		@(negedge clk_sys);
		rx_pop = 1'b0;
		chk(what, exp, rx_o);
		@(negedge clk_sys);
	endtask
	// Plays the master with a bit clock of 24 system cycles
	task automatic t_slave(input ssp_fmt_t f, input logic [7:0] d,
		input logic [7:0] exp);
		logic [7:0] s;
		logic       frm;
		frm = f == SSP_FMT_FRAMED;
		setcfg(1'b0, f, 4'h7, 8'h04, 8'h01);
		// Framed: a clock rise with select high arms the frame
		sclk_in = frm;
		fss_in = frm;
		repeat (12) @(negedge clk_sys);
		sclk_in = 1'b0;
		fss_in = 1'b0;
		repeat (12) @(negedge clk_sys);
		for (int b = 7; b >= 0; b--) begin
			sclk_in = frm;
			sin_b = d[b];
			repeat (12) @(negedge clk_sys);
			sclk_in = !frm;
			s[b] = sout_o;
			repeat (12) @(negedge clk_sys);
		end
		sclk_in = 1'b0;
		repeat (12) @(negedge clk_sys);
		fss_in = !frm;
		sin_b = ~sin_b;
		repeat (12) @(negedge clk_sys);
		chk("slave_tx", {8'h0, exp}, {8'h0, s});
		pop_chk("slave_rx", {8'h0, d});
	endtask
	task automatic t_reset;
		chk("tx_ready", 16'h1, {15'h0, txr_o});
		chk("dma_req", 16'h1, {15'h0, dma_o});
		chk("raw", 16'h8, {12'h0, raw_o});
		chk("sclk", 16'h0, {15'h0, sclk_o});
		chk("fss", 16'h1, {15'h0, fss_o});
		chk("rx_avail", 16'h0, {15'h0, rxa_o});
		chk("sclk_oe", 16'h1, {15'h0, coe_o});
		chk("fss_oe", 16'h1, {15'h0, foe_o});
	endtask
	task automatic t_spi;
		logic [7:0]  ps[2] = '{8'h04, 8'h06};
		logic [7:0]  sr[2] = '{8'h01, 8'h02};
		logic [3:0]  sz[2] = '{4'hf, 4'h3};
		logic [15:0] dt[2] = '{16'hb2c5, 16'h0009};
		logic [15:0] rp[2] = '{16'h6a13, 16'h000e};
		for (int i = 0; i < 2; i++) begin
			setcfg(1'b1, SSP_FMT_SPI, sz[i], ps[i], sr[i]);
			mframe(dt[i], rp[i]);
			chk("spi_tx", dt[i], got);
			chk("spi_bits", 16'(nbits), 16'(rises));
			chk("period", 16'(ps[i] * (sr[i] + 1)), 16'(period));
			pop_chk("spi_rx", rp[i]);
		end
	endtask
	task automatic t_framed;
		setcfg(1'b1, SSP_FMT_FRAMED, 4'h7, 8'h04, 8'h01);
		mframe(16'h005a, 16'h0096);
		chk("fr_tx", 16'h005a, got);
		chk("fr_bits", 16'h8, 16'(rises));
		chk("fr_pulse", 16'h8, 16'(fss_w));
		pop_chk("fr_rx", 16'h0096);
	endtask
	task automatic t_msg;
		setcfg(1'b1, SSP_FMT_MSG, 4'h7, 8'h04, 8'h01);
		mframe(16'h00c3, 16'h00a7);
		chk("msg_ctl", 16'h00c3, got);
		chk("msg_clocks", 16'd17, 16'(rises));
		pop_chk("msg_rx", 16'h00a7);
	endtask
	task automatic t_irq;
		ssp_irq_t m[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
		setcfg(1'b1, SSP_FMT_SPI, 4'h7, 8'h04, 8'h01);
		for (int i = 1; i <= 9; i++)
			mframe(16'(i + 16), 16'(i));
		repeat (20) @(negedge clk_sys);
		chk("raw_all", 16'hf, {12'h0, raw_o});
		chk("rx_avail", 16'h1, {15'h0, rxa_o});
		for (int i = 0; i < 5; i++) begin
			mask = m[i];
			repeat (2) @(negedge clk_sys);
			chk("masked", {12'h0, m[i]}, {12'h0, msk_o});
			chk("irq", {15'h0, m[i] != 4'h0}, {15'h0, irq_o});
		end
		@(negedge clk_sys);
		rx_pop = 1'b1;
		clr_tmo = 1'b1;
		clr_ovr = 1'b1;
		@(negedge clk_sys);
		rx_pop = 1'b0;
		clr_tmo = 1'b0;
		clr_ovr = 1'b0;
		chk("rx_first", 16'h1, rx_o);
		repeat (2) @(negedge clk_sys);
		chk("raw_clr", 16'hc, {12'h0, raw_o});
		repeat (24) @(negedge clk_sys);
		chk("tmo", 16'h1, {15'h0, raw_o.rx_tmo});
		for (int i = 2; i <= 8; i++)
			pop_chk("rx_q", 16'(i));
		chk("rx_drained", 16'h0, {15'h0, rxa_o});
	endtask
	task automatic end_sim;
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk_sys);
		failures++;
		end_sim();
	end
	initial begin
		rst_n = 1'b0;
		cfg = '0;
		mask = '0;
		{clr_tmo, clr_ovr, tx_push, rx_pop, sclk_in, sin_b} = 6'h0;
		fss_in = 1'b1;
		tx_data = 16'h0;
		reply = 16'h0;
		nbits = 5'h8;
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		t_reset();
		t_slave(SSP_FMT_SPI, 8'h6d, 8'h00);
		t_spi();
		t_framed();
		t_msg();
		t_irq();
		t_slave(SSP_FMT_SPI, 8'h4e, hist[hist.size() - 8][7:0]);
		t_slave(SSP_FMT_FRAMED, 8'hb3, hist[hist.size() - 8][7:0]);
		end_sim();
	end
endmodule
`default_nettype wire
